// ===== hdl/reset_cause_and_powerup_timer.sv
// reset sequencer: supply monitors, pin reset, power-up delay, cause flags
// assumes core events are one-cycle pulses on core_clk; pins are asynchronous
//
// Operation
// - only one supply monitor enabled; core monitor outside deep sleep.
// - hold reset while core supply low, then until delay expires.
// - deep-sleep supply monitor works only when config bit 2 is one.
// - deep-sleep trip resets flags, clears hold registers, tristates pins, exits.
// - after deep-sleep trip restart like power cycle, wake flag clear.
// - without regulator, core monitor off; supply monitor follows enable always.
// - brownout flag cleared by core brownout and power-on resets.
// - without regulator brownouts leave brownout flag; power-on still clears.
// - config words compared with complement shadow; mismatch forces reset.
// - mismatch clears the mismatch flag; power-on and brownout set it, other resets leave it.
// - every hard or power reset reloads configuration words.
// - delay timer always on, 5-bit slow-osc count, core held meanwhile.
// - delay counting starts only after power-on pulse clears.
// - pin released after delay starts execution at once if clocked.
// - undefined registers keep values except after cold resets.
// - power-on and brownout set cause flags as tabulated; instruction clears own.
// - pin reset flags depend on mode; every reset loads address zero.
// - watchdog timeout resets in run, resumes at next in idle/sleep.
// - interrupt ending low-power clears sleep flag, resumes at next.
// - stack errors set flags; reset only when stack reset enabled.
// - no hardware event sets the power-on flag back.
// - pin low holds reset; internal resets never drive pin.
`timescale 1ns/1ps
module reset_cause_and_powerup_timer
(
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic        core_supply_low,
    input  wire logic        ext_supply_low,
    input  wire logic        external_reset_pin_n,
    input  wire logic        internal_slow_osc,
    input  wire logic        regulator_present,
    input  wire logic [2:0]  power_mode,
    input  wire logic        clock_source_ok,
    input  wire logic [7:0]  config_live,
    input  wire logic [7:0]  config_shadow,
    input  wire logic        reset_instr_exec,
    input  wire logic        watchdog_timeout,
    input  wire logic        stack_overflow_event,
    input  wire logic        stack_underflow_event,
    input  wire logic        stack_error_reset_enable,
    input  wire logic        interrupt_wake,
    input  wire logic        sleep_instr_exec,
    input  wire logic        clear_watchdog_exec,
    input  wire logic        deep_sleep_wake_event,
    input  wire logic        reset_cause_wr_en,
    input  wire logic [7:0]  reset_cause_wr_data,
    input  wire logic        stack_flag_clear,
    input  wire logic        deep_sleep_flag_clear,
    output logic             core_reset,
    output logic             cold_reset,
    output logic             pc_load,
    output logic             pc_resume,
    output logic             config_reload,
    output logic             core_monitor_enable,
    output logic             supply_monitor_enable,
    output logic             hold_regs_clear,
    output logic             io_tristate,
    output logic             deep_sleep_exit,
    output logic             config_mismatch_flag,
    output logic             reset_instr_flag,
    output logic             watchdog_timeout_flag,
    output logic             sleep_entry_flag,
    output logic             power_on_flag,
    output logic             brownout_flag,
    output logic             stack_overflow_flag,
    output logic             stack_underflow_flag,
    output logic             deep_sleep_wake_flag
);

    reset_seq_pkg::seq_state_s cur;
    reset_seq_pkg::seq_state_s next_cur;

    logic delay_expired;
    logic delay_clear;
    logic osc_tick;
    logic reg_on;
    logic core_low;
    logic ext_low;
    logic pin_high;
    logic ds_mon_en;
    logic core_mon;
    logic ext_mon;
    logic core_trip;
    logic ext_trip;
    logic in_run;
    logic mismatch;
    logic hard;
    logic wake;

    // idle and sleep: where a watchdog timeout wakes instead of resets
    function automatic logic is_idle_sleep(input logic [2:0] mode);
        is_idle_sleep = (mode == reset_seq_pkg::MODE_IDLE) ||
                        (mode == reset_seq_pkg::MODE_SLEEP);
    endfunction : is_idle_sleep

    // power-managed modes that an interrupt can end
    function automatic logic is_low_power(input logic [2:0] mode);
        is_low_power = (mode == reset_seq_pkg::MODE_RUN_LOW) ||
                       is_idle_sleep(mode);
    endfunction : is_low_power

    // only second-stage bits feed logic
    assign reg_on    = cur.sync2[reset_seq_pkg::SYNC_REG];
    assign core_low  = cur.sync2[reset_seq_pkg::SYNC_CORE_LOW];
    assign ext_low   = cur.sync2[reset_seq_pkg::SYNC_EXT_LOW];
    assign pin_high  = cur.sync2[reset_seq_pkg::SYNC_PIN];
    assign osc_tick  = cur.sync2[reset_seq_pkg::SYNC_OSC] && !cur.osc_prev;
    assign ds_mon_en = config_live[reset_seq_pkg::CFG_DSMON_BIT];

    // monitors are mutually exclusive by construction
    assign core_mon = reg_on && (power_mode != reset_seq_pkg::MODE_DEEP_SLEEP);
    assign ext_mon  = reg_on ? ((power_mode == reset_seq_pkg::MODE_DEEP_SLEEP) && ds_mon_en)
                             : ds_mon_en;
    assign core_trip = core_mon && core_low;
    assign ext_trip  = ext_mon && ext_low;
    assign in_run    = (cur.seq == reset_seq_pkg::ST_RUN);

    // config words are being reloaded outside run, so ignore them there
    assign mismatch = in_run &&
                      ((config_live ^ config_shadow) != reset_seq_pkg::CFG_COMPLEMENT);

    // timer held clear while a monitored supply is low, counts once it is released
    assign delay_clear = (cur.seq == reset_seq_pkg::ST_SUPPLY);

    power_up_delay_timer u_delay
    (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .clear    (delay_clear),
        .tick     (osc_tick),
        .expired  (delay_expired)
    );

    always_comb
    begin
        next_cur = cur;
        hard     = 1'b0;
        wake     = 1'b0;
        next_cur.sync1 = {regulator_present, internal_slow_osc, external_reset_pin_n,
                          ext_supply_low, core_supply_low};
        next_cur.sync2 = cur.sync1;
        next_cur.osc_prev        = cur.sync2[reset_seq_pkg::SYNC_OSC];
        next_cur.pc_load         = 1'b0;
        next_cur.pc_resume       = 1'b0;
        next_cur.config_reload   = 1'b0;
        next_cur.hold_regs_clear = 1'b0;
        next_cur.deep_sleep_exit = 1'b0;

        // software writes first so that hardware events below win
        if (reset_cause_wr_en)
        begin
            next_cur.flags.cm  = reset_cause_wr_data[reset_seq_pkg::CAUSE_CM_BIT];
            next_cur.flags.ri  = reset_cause_wr_data[reset_seq_pkg::CAUSE_RI_BIT];
            next_cur.flags.por = reset_cause_wr_data[reset_seq_pkg::CAUSE_POR_BIT];
            next_cur.flags.bor = reset_cause_wr_data[reset_seq_pkg::CAUSE_BOR_BIT];
        end
        if (stack_flag_clear)
        begin
            next_cur.flags.stk_ovf = 1'b0;
            next_cur.flags.stk_unf = 1'b0;
        end
        if (deep_sleep_flag_clear)
        begin
            next_cur.flags.ds_wake = 1'b0;
        end
        if (deep_sleep_wake_event)
        begin
            next_cur.flags.ds_wake = 1'b1;
        end
        if (in_run && sleep_instr_exec)
        begin
            next_cur.flags.to = 1'b1;
            next_cur.flags.pd = 1'b0;
        end
        if (in_run && clear_watchdog_exec)
        begin
            next_cur.flags.to = 1'b1;
            next_cur.flags.pd = 1'b1;
        end

        case (cur.seq)
            reset_seq_pkg::ST_SUPPLY:
            begin
                if (!core_trip && !ext_trip)
                begin
                    next_cur.seq           = reset_seq_pkg::ST_DELAY;
                    next_cur.config_reload = 1'b1;
                end
            end
            reset_seq_pkg::ST_DELAY:
            begin
                // core stays held for the full count
                if (delay_expired)
                begin
                    if (pin_high && clock_source_ok)
                    begin
                        next_cur.seq     = reset_seq_pkg::ST_RUN;
                        next_cur.pc_load = 1'b1;
                    end
                    else
                    begin
                        next_cur.seq = reset_seq_pkg::ST_PIN;
                    end
                end
            end
            reset_seq_pkg::ST_PIN:
            begin
                if (pin_high && clock_source_ok)
                begin
                    next_cur.seq     = reset_seq_pkg::ST_RUN;
                    next_cur.pc_load = 1'b1;
                end
            end
            reset_seq_pkg::ST_RESTART:
            begin
                next_cur.seq     = reset_seq_pkg::ST_RUN;
                next_cur.pc_load = 1'b1;
            end
            reset_seq_pkg::ST_RUN:
            begin
                next_cur.cold_reset  = 1'b0;
                next_cur.io_tristate = 1'b0;
            end
            default:
            begin
                next_cur.seq = reset_seq_pkg::ST_SUPPLY;
            end
        endcase

        if (ext_trip)
        begin
            // behaves as a full power cycle
            next_cur.flags      = reset_seq_pkg::FLAGS_POR;
            next_cur.seq        = reset_seq_pkg::ST_SUPPLY;
            next_cur.cold_reset = 1'b1;
            next_cur.pc_load    = 1'b0;
            if (!cur.supply_tripped)
            begin
                next_cur.hold_regs_clear = 1'b1;
                next_cur.io_tristate     = (power_mode == reset_seq_pkg::MODE_DEEP_SLEEP);
                next_cur.deep_sleep_exit = (power_mode == reset_seq_pkg::MODE_DEEP_SLEEP);
            end
        end
        else if (core_trip)
        begin
            // por and stack flags persist
            next_cur.flags.cm   = 1'b1;
            next_cur.flags.ri   = 1'b1;
            next_cur.flags.to   = 1'b1;
            next_cur.flags.pd   = 1'b1;
            next_cur.flags.bor  = 1'b0;
            next_cur.seq        = reset_seq_pkg::ST_SUPPLY;
            next_cur.cold_reset = 1'b1;
            next_cur.pc_load    = 1'b0;
        end
        else if (!pin_high)
        begin
            // pin held low keeps the core in reset from any later state
            if (in_run || (cur.seq == reset_seq_pkg::ST_RESTART))
            begin
                if (power_mode == reset_seq_pkg::MODE_RUN_LOW)
                begin
                    next_cur.flags.to = 1'b1;
                end
                else if (is_idle_sleep(power_mode))
                begin
                    next_cur.flags.to = 1'b1;
                    next_cur.flags.pd = 1'b0;
                end
                next_cur.config_reload = 1'b1;
            end
            if (cur.seq != reset_seq_pkg::ST_SUPPLY && cur.seq != reset_seq_pkg::ST_DELAY)
            begin
                next_cur.seq     = reset_seq_pkg::ST_PIN;
                next_cur.pc_load = 1'b0;
            end
        end
        else if (in_run)
        begin
            if (mismatch)
            begin
                next_cur.flags.cm = 1'b0;
                hard = 1'b1;
            end
            if (reset_instr_exec)
            begin
                next_cur.flags.ri = 1'b0;
                hard = 1'b1;
            end
            if (stack_overflow_event)
            begin
                next_cur.flags.stk_ovf = 1'b1;
                hard = hard || stack_error_reset_enable;
            end
            if (stack_underflow_event)
            begin
                next_cur.flags.stk_unf = 1'b1;
                hard = hard || stack_error_reset_enable;
            end
            if (watchdog_timeout)
            begin
                next_cur.flags.to = 1'b0;
                if (is_idle_sleep(power_mode))
                begin
                    next_cur.flags.pd = 1'b0;
                    wake = 1'b1;
                end
                else
                begin
                    hard = 1'b1;
                end
            end
            if (interrupt_wake && is_low_power(power_mode))
            begin
                next_cur.flags.pd = 1'b0;
                wake = 1'b1;
            end
            if (hard)
            begin
                // one held cycle lets the config words reload before restart
                next_cur.seq           = reset_seq_pkg::ST_RESTART;
                next_cur.config_reload = 1'b1;
            end
            else if (wake)
            begin
                next_cur.pc_load   = 1'b1;
                next_cur.pc_resume = 1'b1;
            end
        end

        next_cur.supply_tripped = ext_trip || core_trip;
        next_cur.core_reset     = (next_cur.seq != reset_seq_pkg::ST_RUN);
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cur <= reset_seq_pkg::SEQ_RESET;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign core_reset            = cur.core_reset;
    assign cold_reset            = cur.cold_reset;
    assign pc_load               = cur.pc_load;
    assign pc_resume             = cur.pc_resume;
    assign config_reload         = cur.config_reload;
    assign core_monitor_enable   = core_mon;
    assign supply_monitor_enable = ext_mon;
    assign hold_regs_clear       = cur.hold_regs_clear;
    assign io_tristate           = cur.io_tristate;
    assign deep_sleep_exit       = cur.deep_sleep_exit;
    assign config_mismatch_flag  = cur.flags.cm;
    assign reset_instr_flag      = cur.flags.ri;
    assign watchdog_timeout_flag = cur.flags.to;
    assign sleep_entry_flag      = cur.flags.pd;
    assign power_on_flag         = cur.flags.por;
    assign brownout_flag         = cur.flags.bor;
    assign stack_overflow_flag   = cur.flags.stk_ovf;
    assign stack_underflow_flag  = cur.flags.stk_unf;
    assign deep_sleep_wake_flag  = cur.flags.ds_wake;

endmodule : reset_cause_and_powerup_timer

// ===== hdl/reset_seq_pkg.sv
// constants, field layouts and state types for the reset sequencer
// assumes the core and config memory share core_clk; pins arrive unsynchronised
package reset_seq_pkg;

    // power-mode encoding driven by the core
    localparam logic [2:0] MODE_RUN_FULL   = 3'h0;
    localparam logic [2:0] MODE_RUN_LOW    = 3'h1;
    localparam logic [2:0] MODE_IDLE       = 3'h2;
    localparam logic [2:0] MODE_SLEEP      = 3'h3;
    localparam logic [2:0] MODE_DEEP_SLEEP = 3'h4;

    // reset-cause write data bit positions
    localparam int CAUSE_BOR_BIT = 0;
    localparam int CAUSE_POR_BIT = 1;
    localparam int CAUSE_CM_BIT  = 5;
    localparam int CAUSE_RI_BIT  = 4;
    localparam int CAUSE_W       = 8;

    // configuration word layout
    localparam int CFG_W         = 8;
    localparam int CFG_DSMON_BIT = 2;
    localparam logic [CFG_W-1:0] CFG_COMPLEMENT = 8'hFF;

    // power-up delay: 5-bit counter of slow-oscillator ticks
    localparam int             POWER_UP_DELAY_TIMER_W        = 5;
    localparam logic [POWER_UP_DELAY_TIMER_W-1:0] POWER_UP_DELAY_TIMER_LAST  = 5'h1F;
    localparam int             OSC_PERIOD_US = 32;
    localparam int             POWER_UP_DELAY_TIMER_TICKS    = 32;
    localparam int             POWER_UP_DELAY_TIMER_PERIOD_US = POWER_UP_DELAY_TIMER_TICKS * OSC_PERIOD_US;

    // synchroniser lanes
    localparam int SYNC_CORE_LOW = 0;
    localparam int SYNC_EXT_LOW  = 1;
    localparam int SYNC_PIN      = 2;
    localparam int SYNC_OSC      = 3;
    localparam int SYNC_REG      = 4;
    localparam int SYNC_W        = 5;
    localparam logic [SYNC_W-1:0] SYNC_RESET = 5'h00;

    typedef enum logic [2:0] {
        ST_SUPPLY,
        ST_DELAY,
        ST_PIN,
        ST_RESTART,
        ST_RUN
    } seq_state_e;

    typedef struct packed {
        logic cm;
        logic ri;
        logic to;
        logic pd;
        logic por;
        logic bor;
        logic stk_ovf;
        logic stk_unf;
        logic ds_wake;
    } cause_flags_s;

    localparam cause_flags_s FLAGS_POR = '{
        cm: 1'b1, ri: 1'b1, to: 1'b1, pd: 1'b1, por: 1'b0,
        bor: 1'b0, stk_ovf: 1'b0, stk_unf: 1'b0, ds_wake: 1'b0};

    typedef struct packed {
        logic [POWER_UP_DELAY_TIMER_W-1:0] count;
        logic              expired;
    } delay_state_s;

    localparam delay_state_s DELAY_RESET = '{count: 5'h00, expired: 1'b0};

    typedef struct packed {
        logic [SYNC_W-1:0] sync1;
        logic [SYNC_W-1:0] sync2;
        logic              osc_prev;
        seq_state_e        seq;
        cause_flags_s      flags;
        logic              core_reset;
        logic              cold_reset;
        logic              pc_load;
        logic              pc_resume;
        logic              config_reload;
        logic              hold_regs_clear;
        logic              io_tristate;
        logic              deep_sleep_exit;
        logic              supply_tripped;
    } seq_state_s;

    localparam seq_state_s SEQ_RESET = '{
        sync1: SYNC_RESET, sync2: SYNC_RESET, osc_prev: 1'b0,
        seq: ST_SUPPLY, flags: FLAGS_POR, core_reset: 1'b1,
        cold_reset: 1'b1, pc_load: 1'b0, pc_resume: 1'b0,
        config_reload: 1'b0, hold_regs_clear: 1'b0, io_tristate: 1'b0,
        deep_sleep_exit: 1'b0, supply_tripped: 1'b1};

endpackage : reset_seq_pkg

// ===== hdl/power_up_delay_timer.sv
// power-up delay counter, advanced by slow-oscillator tick pulses
// assumes tick is a one-cycle pulse already in the core_clk domain
`timescale 1ns/1ps
module power_up_delay_timer
(
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic clear,
    input  wire logic tick,
    output logic      expired
);

    reset_seq_pkg::delay_state_s cur;
    reset_seq_pkg::delay_state_s next_cur;

    always_comb
    begin
        next_cur = cur;
        if (clear)
        begin
            next_cur = reset_seq_pkg::DELAY_RESET;
        end
        else if (tick && !cur.expired)
        begin
            if (cur.count == reset_seq_pkg::POWER_UP_DELAY_TIMER_LAST)
            begin
                next_cur.expired = 1'b1;
            end
            else
            begin
                next_cur.count = cur.count + 5'h01;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cur <= reset_seq_pkg::DELAY_RESET;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign expired = cur.expired;

endmodule : power_up_delay_timer

// ===== tb/reset_seq_monitor.sv
// checker for the reset sequencer, bound to its top module
// assumes core events are one-cycle pulses and the clock source stays up
`timescale 1ns/1ps
module reset_seq_monitor
(
    input wire logic       core_clk,
    input wire logic       reset_n,
    input wire logic       core_supply_low,
    input wire logic       external_reset_pin_n,
    input wire logic [2:0] power_mode,
    input wire logic [7:0] config_live,
    input wire logic [7:0] config_shadow,
    input wire logic       reset_instr_exec,
    input wire logic       watchdog_timeout,
    input wire logic       interrupt_wake,
    input wire logic       reset_cause_wr_en,
    input wire logic       core_reset,
    input wire logic       pc_load,
    input wire logic       pc_resume,
    input wire logic       config_reload,
    input wire logic       core_monitor_enable,
    input wire logic       supply_monitor_enable,
    input wire logic       config_mismatch_flag,
    input wire logic       reset_instr_flag,
    input wire logic       watchdog_timeout_flag,
    input wire logic       sleep_entry_flag,
    input wire logic       power_on_flag
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // reset, watchdog and interrupt events are ignored while held, so every such antecedent needs run
    wire run = !core_reset;
    wire lp  = power_mode == 3'h2 || power_mode == 3'h3;
    a_one_monitor: assert property (!(core_monitor_enable && supply_monitor_enable))
        else $error("both supply monitors on");
    a_supply_hold: assert property (
        (core_supply_low && core_monitor_enable)[*5] |-> core_reset)
        else $error("core runs on low supply");
    a_pin_hold: assert property ((!external_reset_pin_n)[*5] |-> core_reset)
        else $error("core runs with pin low");
    a_instr_reset: assert property (reset_instr_exec && run |=>
        core_reset && config_reload && !reset_instr_flag ##1 pc_load && !pc_resume)
        else $error("reset instruction sequence wrong");
    a_wdt_wake: assert property (watchdog_timeout && run && lp |=>
        pc_load && pc_resume && !watchdog_timeout_flag && !sleep_entry_flag)
        else $error("watchdog wake wrong");
    a_intr_wake: assert property (interrupt_wake && run && power_mode == 3'h3 |=>
        pc_load && pc_resume && !sleep_entry_flag && $stable(watchdog_timeout_flag))
        else $error("interrupt wake wrong");
    a_mismatch_reset: assert property (
        run && (config_live ^ config_shadow) != 8'hFF |=> core_reset && !config_mismatch_flag)
        else $error("mismatch not reset");
    a_por_write: assert property ($rose(power_on_flag) |-> $past(reset_cause_wr_en))
        else $error("power-on flag set by hardware");
    c_wdt_wake: cover property (watchdog_timeout && run && lp);
    c_intr_wake: cover property (interrupt_wake && run && power_mode == 3'h3);
    c_mismatch: cover property (run && (config_live ^ config_shadow) != 8'hFF);
endmodule : reset_seq_monitor

bind reset_cause_and_powerup_timer reset_seq_monitor i_monitor (.*);

// ===== tb/core_model.sv
// core model: counts address loads to zero and to the next address
// assumes pc_resume is valid in the cycle of each pc_load pulse
`timescale 1ns/1ps
module core_model
(
    input  wire logic core_clk,
    input  wire logic pc_load,
    input  wire logic pc_resume,
    output int        zero_loads,
    output int        resume_loads
);
    // counts only; the bench holds no address, so a wrong target shows as a count
    always @(posedge core_clk)
        if (pc_load && pc_resume)
            resume_loads <= resume_loads + 1;
        else if (pc_load)
            zero_loads <= zero_loads + 1;
endmodule : core_model

// ===== tb/reset_cause_and_powerup_timer_bench.sv
// bench: random core events and supply trips against a flag model
// assumes slow osc at one eighth of core_clk, clock source always up
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((e) !== (g)) begin err_count++; \
    $display("Error %s expected %0h seen %0h", n, e, g); end end
module reset_cause_and_powerup_timer_bench;
    localparam int OSC = 8;
    logic        core_clk = 1'h0, reset_n = 1'h0, core_supply_low = 1'h0;
    logic        ext_supply_low = 1'h0, external_reset_pin_n = 1'h1, internal_slow_osc = 1'h0;
    logic        regulator_present = 1'h1, clock_source_ok = 1'h1, deep_sleep_wake_event = 1'h0;
    logic        stack_error_reset_enable = 1'h0;
    logic [2:0]  power_mode = 3'h0;
    logic [7:0]  config_live = 8'h04, config_shadow = 8'hFB, reset_cause_wr_data = 8'h00;
    logic [9:0]  evt = 10'h000;
    logic [8:0]  m;
    logic [4:0]  seen = 5'h00;
    logic [31:0] rnd = 32'h2F78;
    int          err_count, n_compared, cycles, n_zero, n_resume, zero_loads, resume_loads;
    wire reset_instr_exec = evt[0], watchdog_timeout = evt[1], stack_overflow_event = evt[2];
    wire stack_underflow_event = evt[3], interrupt_wake = evt[4], sleep_instr_exec = evt[5];
    wire clear_watchdog_exec = evt[6], reset_cause_wr_en = evt[7], stack_flag_clear = evt[8];
    wire deep_sleep_flag_clear = evt[9];
    wire core_reset, cold_reset, pc_load, pc_resume, config_reload, core_monitor_enable;
    wire supply_monitor_enable, hold_regs_clear, io_tristate, deep_sleep_exit;
    wire config_mismatch_flag, reset_instr_flag, watchdog_timeout_flag, sleep_entry_flag;
    wire power_on_flag, brownout_flag, stack_overflow_flag, stack_underflow_flag;
    wire deep_sleep_wake_flag;
    wire [8:0] flags = {config_mismatch_flag, reset_instr_flag, watchdog_timeout_flag,
        sleep_entry_flag, power_on_flag, brownout_flag, stack_overflow_flag,
        stack_underflow_flag, deep_sleep_wake_flag};
    reset_cause_and_powerup_timer i_dut (.*);
    core_model i_core (.core_clk(core_clk), .pc_load(pc_load), .pc_resume(pc_resume),
        .zero_loads(zero_loads), .resume_loads(resume_loads));
    always #2.5 core_clk = ~core_clk;
    // fast slow-osc keeps the 32-tick delay near 256 core cycles
    always #(OSC * 2.5) internal_slow_osc = ~internal_slow_osc;
    always @(posedge core_clk)
        if (reset_n)
            seen <= seen | {cold_reset, config_reload, hold_regs_clear, io_tristate,
                deep_sleep_exit};
    always @(posedge core_clk)
        if (++cycles == 30000)
            give_verdict(1);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic give_verdict(input int extra);
        err_count += extra;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict
    task automatic compare;
        `CHK("running", 1'h0, core_reset)
        `CHK("flags", m, flags)
        `CHK("zero loads", n_zero, zero_loads)
        `CHK("resume loads", n_resume, resume_loads)
    endtask : compare
    task automatic release_wait(input logic [4:0] exp_seen);
        int n;
        n = 0;
        while (core_reset !== 1'h0 && n < 2000)
        begin
            @(negedge core_clk);
            n++;
        end
        `CHK("delay", 1'h1, n >= 31 * OSC && n <= 35 * OSC)
        repeat (3) @(negedge core_clk);
        n_zero++;
        `CHK("pulses", exp_seen, seen)
        compare();
    endtask : release_wait
    task automatic ev(input int k, input logic [7:0] d);
        logic lp;
        lp = power_mode inside {3'h2, 3'h3};
        reset_cause_wr_data = d;
        deep_sleep_wake_event = k == 9 && d[0];
        if (k < 10)
            evt = 10'h001 << k;
        else if (k == 10)
            config_shadow[3] = ~config_shadow[3];
        else
            external_reset_pin_n = 1'h0;
        @(negedge core_clk);
        evt = 10'h000;
        deep_sleep_wake_event = 1'h0;
        config_shadow = ~config_live;
        repeat (6) @(negedge core_clk);
        external_reset_pin_n = 1'h1;
        repeat (6) @(negedge core_clk);
        case (k)
            0: m[7] = 1'h0;
            1: m[6:5] = {1'h0, m[5] & !lp};
            2: m[2] = 1'h1;
            3: m[1] = 1'h1;
            4: m[5] = m[5] & (power_mode == 3'h0);
            5: m[6:5] = 2'h2;
            6: m[6:5] = 2'h3;
            7: {m[8:7], m[4:3]} = {d[5:4], d[1:0]};
            8: m[2:1] = 2'h0;
            9: m[0] = d[0];
            10: m[8] = 1'h0;
            default: m[6:5] = {m[6] | (power_mode != 3'h0), m[5] & !lp};
        endcase
        n_resume += int'((k == 1 && lp) || (k == 4 && power_mode != 3'h0));
        n_zero += int'(k == 0 || k >= 10 || (k == 1 && !lp)
            || (k inside {2, 3} && stack_error_reset_enable));
        compare();
    endtask : ev
    task automatic trip(input logic ext);
        seen = 5'h00;
        power_mode = ext ? 3'h4 : 3'h0;
        {ext_supply_low, core_supply_low} = {ext, !ext};
        repeat (12) @(negedge core_clk);
        `CHK("monitors", {!ext, ext}, {core_monitor_enable, supply_monitor_enable})
        {ext_supply_low, core_supply_low} = 2'h0;
        power_mode = 3'h0;
        m = ext ? 9'h1E0 : {4'hF, m[4], 1'h0, m[2:0]};
        release_wait(ext ? 5'h1F : 5'h18);
    endtask : trip
    initial
    begin
        repeat (4) @(negedge core_clk);
        reset_n = 1'h1;
        m = 9'h1E0;
        release_wait(5'h18);
        ev(7, 8'hFF);
        for (int i = 0; i < 150; i++)
        begin
            rnd = lfsr(rnd);
            power_mode = {1'h0, rnd[1:0]};
            stack_error_reset_enable = rnd[8];
            ev(int'(rnd[15:4] % 12), rnd[23:16]);
        end
        trip(1'h0);
        trip(1'h1);
        regulator_present = 1'h0;
        repeat (3) @(negedge core_clk);
        `CHK("no regulator", 2'h1, {core_monitor_enable, supply_monitor_enable})
        give_verdict(0);
    end
endmodule : reset_cause_and_powerup_timer_bench
